/* hw/fclr_edge.sv */
`timescale 1ns/10ps
`include "infm_map.svh"

module fclr_edge
  import infm_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic level,
  output logic      pulse
);
  import infm_pkg::*;

  fclr_state_t state_r;
  fclr_state_t state_nxt;
  logic        pulse_r;
  logic        pulse_nxt;

  // ----------------------------------------
  // Fall detect
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    pulse_nxt = 1'b0;
    case (state_r)
      FC_IDLE: if (level) state_nxt = FC_ON;
      FC_ON:
      begin
        if (!level)
        begin
          state_nxt = FC_IDLE;
          pulse_nxt = 1'b1;
        end
      end
      default: state_nxt = FC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      state_r <= FC_IDLE;
      pulse_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

  property p_fall;
    @(posedge CLK_SYS) disable iff (!RST_N)
    level ##1 !level |=> pulse;
  endproperty
  a_fall: assert property (p_fall) else $error("fall not seen");
endmodule // fclr_edge

/* hw/infm_map.svh */
`ifndef INFM_MAP_SVH
`define INFM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FSEL0       8'h00
`define OFS_FSEL6       8'h18
`define OFS_CONTACT     8'h20
`define OFS_FUNC_STAT   8'h24
`define OFS_FLAG_STAT   8'h28
`define OFS_TERM_STAT   8'h2C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FSEL0       6'h01
`define RST_FSEL1       6'h02
`define RST_FSEL2       6'h13
`define RST_FSEL3       6'h30
`define RST_FSEL4       6'h18
`define RST_FSEL5       6'h14
`define RST_FSEL6       6'h16
`define RST_CONTACT     7'h00

// ----------------------------------------
// Function status bit positions
// ----------------------------------------
`define FS_FWD          0
`define FS_REV          1
`define FS_STOPSEL      2
`define FS_BRAKE        3
`define FS_EXTFLT       4
`define FS_THERM        5
`define FS_FCLR         6
`define FS_UNLOCK       7
`define FS_TLDIS        8
`define FS_OPSEL        12

`endif

/* hw/infm_pkg.sv */
package infm_pkg;
  typedef logic [5:0] fsel_t;
  typedef enum logic [5:0] {
    FN_UNUSED  = 6'h00,
    FN_FWD     = 6'h01,
    FN_REV     = 6'h02,
    FN_STOPSEL = 6'h13,
    FN_BRAKE   = 6'h14,
    FN_EXTFLT  = 6'h15,
    FN_THERM   = 6'h16,
    FN_FCLR    = 6'h18,
    FN_UNLOCK  = 6'h1B,
    FN_FLAG0   = 6'h20,
    FN_OPSEL0  = 6'h30,
    FN_TLDIS   = 6'h36
  } func_code_t;
  typedef enum logic [1:0] {
    FC_IDLE = 2'b00,
    FC_ON   = 2'b01
  } fclr_state_t;
endpackage

/* hw/input_function_mapper.sv */
`timescale 1ns/10ps
`include "infm_map.svh"

// Overview of operation
// - Seven input terminals, each routed by its own function-select code.
// - Reset codes: 1, 2, 19, 48, 24, 20, 22 for terminals 0..6.
// - Code 0 leaves the terminal unused.
// - Code 1 forward run, code 2 reverse run.
// - Code 19 selects instantaneous or decelerating stop.
// - Code 20 releases the brake.
// - Codes 21, 22 external fault and thermal stop, normally closed.
// - Code 24 fault clear, acts on ON to OFF transition.
// - Code 27 tool unlock, normally closed.
// - Codes 32..47 sixteen general flags in order.
// - Codes 48..51 four operation data select bits.
// - Code 54 torque limit disable, normally closed.
// - Function on several terminals is the OR of them.
// - Unassigned unlock and torque-limit disable read ON.
// - Unlock and torque-limit disable on several terminals is AND.
// - Contact type per terminal: 0 normally open, 1 inverted; reset 0.
module input_function_mapper
  import infm_pkg::*;
#(
  parameter int N_TERM = 7
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [6:0]  INPUT_TERMINAL,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             FORWARD_RUN_CMD,
  output logic             REVERSE_RUN_CMD,
  output logic             STOP_STYLE_SEL,
  output logic             BRAKE_RELEASE,
  output logic             EXTERNAL_FAULT_STOP,
  output logic             THERMAL_TRIP_STOP,
  output logic             FAULT_CLEAR_PULSE,
  output logic             TOOL_UNLOCK,
  output logic             TORQUE_LIMIT_DISABLE,
  output logic [15:0]      GENERAL_FLAG,
  output logic [3:0]       OP_SELECT
);
  import infm_pkg::*;

  fsel_t       fsel_r [N_TERM];
  fsel_t       fsel_nxt [N_TERM];
  logic [6:0]  contact_r;
  logic [6:0]  contact_nxt;
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [6:0]  act;
  logic [31:0] func_r;
  logic [31:0] func_nxt;
  logic [15:0] flag_r;
  logic [15:0] flag_nxt;
  logic        fclr_lvl;
  logic        fclr_pulse;
  logic        addr_ok;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic any_code(input logic [6:0] a, input fsel_t s [N_TERM],
                                    input fsel_t c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_TERM; i++)
      if (s[i] == c && a[i]) r = 1'b1;
    return r;
  endfunction

  function automatic logic and_code(input logic [6:0] a, input fsel_t s [N_TERM],
                                    input fsel_t c);
    logic r;
    r = 1'b1;
    for (int i = 0; i < N_TERM; i++)
      if (s[i] == c && !a[i]) r = 1'b0;
    return r;
  endfunction

  function automatic fsel_t rst_fsel(input int i);
    fsel_t r;
    case (i)
      0: r = `RST_FSEL0;
      1: r = `RST_FSEL1;
      2: r = `RST_FSEL2;
      3: r = `RST_FSEL3;
      4: r = `RST_FSEL4;
      5: r = `RST_FSEL5;
      default: r = `RST_FSEL6;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Contact sense
  // ----------------------------------------
  assign act = INPUT_TERMINAL ^ contact_r;

  // ----------------------------------------
  // Function decode
  // ----------------------------------------
  always_comb
  begin
    func_nxt = 32'h0;
    flag_nxt = 16'h0;
    // Unused or unlisted codes match nothing below
    func_nxt[`FS_FWD]     = any_code(act, fsel_r, FN_FWD);
    func_nxt[`FS_REV]     = any_code(act, fsel_r, FN_REV);
    func_nxt[`FS_STOPSEL] = any_code(act, fsel_r, FN_STOPSEL);
    func_nxt[`FS_BRAKE]   = any_code(act, fsel_r, FN_BRAKE);
    // Normally closed stops act when contact opens
    func_nxt[`FS_EXTFLT]  = any_code(~act, fsel_r, FN_EXTFLT);
    func_nxt[`FS_THERM]   = any_code(~act, fsel_r, FN_THERM);
    func_nxt[`FS_FCLR]    = any_code(act, fsel_r, FN_FCLR);
    func_nxt[`FS_UNLOCK]  = and_code(act, fsel_r, FN_UNLOCK);
    func_nxt[`FS_TLDIS]   = and_code(act, fsel_r, FN_TLDIS);
    for (int b = 0; b < 4; b++)
      func_nxt[`FS_OPSEL + b] =
        any_code(act, fsel_r, fsel_t'(FN_OPSEL0 + b));
    for (int f = 0; f < 16; f++)
      flag_nxt[f] = any_code(act, fsel_r, fsel_t'(FN_FLAG0 + f));
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      func_r <= 32'h0;
      flag_r <= 16'h0;
    end
    else
    begin
      func_r <= func_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign fclr_lvl = func_r[`FS_FCLR];

  fclr_edge u_fclr (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .level   (fclr_lvl),
    .pulse   (fclr_pulse)
  );

  assign FORWARD_RUN_CMD      = func_r[`FS_FWD];
  assign REVERSE_RUN_CMD      = func_r[`FS_REV];
  assign STOP_STYLE_SEL       = func_r[`FS_STOPSEL];
  assign BRAKE_RELEASE        = func_r[`FS_BRAKE];
  assign EXTERNAL_FAULT_STOP  = func_r[`FS_EXTFLT];
  assign THERMAL_TRIP_STOP    = func_r[`FS_THERM];
  assign FAULT_CLEAR_PULSE    = fclr_pulse;
  assign TOOL_UNLOCK          = func_r[`FS_UNLOCK];
  assign TORQUE_LIMIT_DISABLE = func_r[`FS_TLDIS];
  assign GENERAL_FLAG         = flag_r;
  assign OP_SELECT            = func_r[`FS_OPSEL +: 4];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  wire addr_phase = HSEL && HREADY && HTRANS[1];

  always_comb
  begin
    addr_ok = (HADDR[7:0] <= `OFS_TERM_STAT) && (HADDR[1:0] == 2'b00)
              && (HADDR[7:0] != 8'h1C);
  end

  // Parameter writes from the link or tool
  always_comb
  begin
    wr_pend_nxt = addr_phase && HWRITE && addr_ok;
    wr_addr_nxt = addr_phase ? HADDR[7:0] : wr_addr_r;
    contact_nxt = contact_r;
    rdata_nxt   = rdata_r;
    for (int i = 0; i < N_TERM; i++)
      fsel_nxt[i] = fsel_r[i];
    if (wr_pend_r)
    begin
      if (wr_addr_r == `OFS_CONTACT)
        contact_nxt = HWDATA[6:0];
      else
        for (int i = 0; i < N_TERM; i++)
          if (wr_addr_r == 8'(`OFS_FSEL0 + 4 * i))
            fsel_nxt[i] = HWDATA[5:0];
    end
    if (addr_phase && !HWRITE)
    begin
      rdata_nxt = 32'h0;
      if (HADDR[7:0] == `OFS_CONTACT)
        rdata_nxt = {25'h0, contact_r};
      else if (HADDR[7:0] == `OFS_FUNC_STAT)
        rdata_nxt = {func_r[31:7], fclr_pulse, func_r[5:0]};
      else if (HADDR[7:0] == `OFS_FLAG_STAT)
        rdata_nxt = {16'h0, flag_r};
      else if (HADDR[7:0] == `OFS_TERM_STAT)
        rdata_nxt = {25'h0, INPUT_TERMINAL};
      else
        for (int i = 0; i < N_TERM; i++)
          if (HADDR[7:0] == 8'(`OFS_FSEL0 + 4 * i))
            rdata_nxt = {26'h0, fsel_r[i]};
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < N_TERM; i++)
        fsel_r[i] <= rst_fsel(i);
      contact_r <= `RST_CONTACT;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0;
    end
    else
    begin
      for (int i = 0; i < N_TERM; i++)
        fsel_r[i] <= fsel_nxt[i];
      contact_r <= contact_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign HRDATA    = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_fwd;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[0] == FN_FWD && contact_r[0] == 1'b0 && INPUT_TERMINAL[0]) |=> FORWARD_RUN_CMD;
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd not mapped");

  property p_unused;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[1] == FN_UNUSED && fsel_r[0] != FN_REV && fsel_r[2] != FN_REV
     && fsel_r[3] != FN_REV && fsel_r[4] != FN_REV && fsel_r[5] != FN_REV
     && fsel_r[6] != FN_REV) |=> !REVERSE_RUN_CMD;
  endproperty
  a_unused: assert property (p_unused) else $error("unused drives rev");

  property p_therm;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[6] == FN_THERM && !act[6]) |=> THERMAL_TRIP_STOP;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal not nc");

  property p_tldis_and;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[0] == FN_TLDIS && !act[0]) |=> !TORQUE_LIMIT_DISABLE;
  endproperty
  a_tldis_and: assert property (p_tldis_and) else $error("tl and fail");

  property p_reset_vals;
    @(posedge CLK_SYS) $rose(RST_N) |-> fsel_r[3] == FN_OPSEL0 && contact_r == 7'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset");

  property p_opsel;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[3] == FN_OPSEL0 && act[3]) |=> OP_SELECT[0];
  endproperty
  a_opsel: assert property (p_opsel) else $error("select lsb");

  property p_flag;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[1] == 6'h2F && act[1]) |=> GENERAL_FLAG[15];
  endproperty
  a_flag: assert property (p_flag) else $error("flag order");

  property p_invert;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (fsel_r[5] == FN_BRAKE && contact_r[5] && !INPUT_TERMINAL[5]) |=> BRAKE_RELEASE;
  endproperty
  a_invert: assert property (p_invert) else $error("contact sense");

  c_fclr: cover property (@(posedge CLK_SYS) disable iff (!RST_N) FAULT_CLEAR_PULSE);
  c_write: cover property (@(posedge CLK_SYS) disable iff (!RST_N) wr_pend_r);
  c_unlock_off: cover property (@(posedge CLK_SYS) disable iff (!RST_N) !TOOL_UNLOCK);
endmodule // input_function_mapper

/* sim/contact_bank.sv */
`timescale 1ns/10ps
// ----
// Contacts at the terminals
// ----
module contact_bank
(
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [6:0] cmd,
  output logic      [6:0] level
);
  logic [6:0] stage_r;
  // Slow contacts settle one cycle late
  always_ff @(posedge clk)
  begin
    stage_r <= cmd;
    level   <= slow ? stage_r : cmd;
  end
endmodule // contact_bank

/* sim/tb_input_function_mapper.sv */
`timescale 1ns/10ps
`include "infm_map.svh"
module tb_input_function_mapper
  import infm_pkg::*;
;
  // ----
  // Signals
  // ----
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic        fclr, hrdy, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h0000C5AC;
  logic [6:0]  cmd = 7'h00, ct = 7'h00, term;
  wire  [27:0] outs;
  fsel_t       fs [7] = '{6'h01, 6'h02, 6'h13, 6'h30, 6'h18, 6'h14, 6'h16};
  fsel_t       codes [16] = '{6'h00, 6'h01, 6'h02, 6'h13, 6'h14, 6'h15, 6'h16, 6'h18,
                              6'h1B, 6'h20, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33, 6'h36};
  fsel_t       dup [5] = '{6'h02, 6'h1B, 6'h36, 6'h00, 6'h3F};
  int          n_errors = 0, checks_done = 0, cyc = 0;

  always #25 clk = ~clk;

  contact_bank partner (.clk(clk), .slow(slow), .cmd(cmd), .level(term));

  input_function_mapper uut (
    .CLK_SYS(clk), .RST_N(rst_n), .INPUT_TERMINAL(term), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .FORWARD_RUN_CMD(outs[27]),
    .REVERSE_RUN_CMD(outs[26]), .STOP_STYLE_SEL(outs[25]), .BRAKE_RELEASE(outs[24]),
    .EXTERNAL_FAULT_STOP(outs[23]), .THERMAL_TRIP_STOP(outs[22]), .FAULT_CLEAR_PULSE(fclr),
    .TOOL_UNLOCK(outs[21]), .TORQUE_LIMIT_DISABLE(outs[20]), .GENERAL_FLAG(outs[19:4]),
    .OP_SELECT(outs[3:0]));

  // ----
  // Tasks
  // ----
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic setf(input int i, input fsel_t c);
    ahb(1'b1, 32'(`OFS_FSEL0 + 4 * i), {26'h0, c}, rd);
    fs[i] = c;
  endtask

  function automatic logic [27:0] expect_out(input logic [6:0] t);
    logic [5:0] f;
    logic [15:0] fg;
    logic [3:0] op;
    logic [7:0] v;
    logic e;
    v = 8'h03;
    fg = 16'h0;
    op = 4'h0;
    for (int i = 0; i < 7; i++)
    begin
      e = t[i] ^ ct[i];
      f = fs[i];
      case (f)
        6'h01: v[7] |= e;
        6'h02: v[6] |= e;
        6'h13: v[5] |= e;
        6'h14: v[4] |= e;
        6'h15: v[3] |= !e;
        6'h16: v[2] |= !e;
        6'h1B: v[1] &= e;
        6'h36: v[0] &= e;
        default:
          if (f >= 6'h20 && f <= 6'h2F) fg[f - 6'h20] |= e;
          else if (f >= 6'h30 && f <= 6'h33) op[f - 6'h30] |= e;
      endcase
    end
    return {v, fg, op};
  endfunction

  task automatic apply(input logic [6:0] t);
    logic [27:0] e;
    e = expect_out(t);
    @(posedge clk);
    cmd <= t;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(outs), 32'(e));
    ahb(1'b0, 32'(`OFS_FUNC_STAT), 32'h0, rd);
    chk(rd, {16'h0, e[3:0], 3'h0, e[20], e[21], 1'b0, e[22], e[23], e[24], e[25], e[26],
             e[27]});
    ahb(1'b0, 32'(`OFS_FLAG_STAT), 32'h0, rd);
    chk(rd, {16'h0, e[19:4]});
    ahb(1'b0, 32'(`OFS_TERM_STAT), 32'h0, rd);
    chk(rd, {25'h0, t});
    chk({30'h0, hrdy, hresp}, 32'h2);
  endtask

  task automatic watch(output int n, output int first);
    n = 0;
    first = 0;
    for (int k = 1; k <= 8; k++)
    begin
      @(posedge clk);
      #1;
      if (fclr === 1'b1)
      begin
        if (n == 0) first = k;
        n++;
      end
    end
  endtask

  // ----
  // Sequence
  // ----
  initial
  begin
    int p, at;
    logic [31:0] r;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      ahb(1'b0, 32'(`OFS_FSEL0 + 4 * i), 32'h0, rd);
      chk(rd, {26'h0, fs[i]});
    end
    ahb(1'b0, 32'(`OFS_CONTACT), 32'h0, rd);
    chk(rd, 32'h0);
    apply(7'h00);
    apply(7'h7F);
    apply(7'h2A);
    $display("test defaults done");
    @(posedge clk);
    cmd <= 7'h10;
    watch(p, at);
    chk(32'(p), 32'h0);
    @(posedge clk);
    cmd <= 7'h00;
    watch(p, at);
    chk(32'(p), 32'h1);
    chk(32'(at), 32'h3);
    $display("test fault clear done");
    ahb(1'b1, 32'(`OFS_CONTACT), 32'h7F, rd);
    ct = 7'h7F;
    apply(7'h0F);
    ahb(1'b1, 32'(`OFS_CONTACT), 32'h0, rd);
    ct = 7'h00;
    foreach (dup[j])
    begin
      for (int i = 0; i < 7; i++) setf(i, dup[j]);
      apply(7'h01);
      apply(7'h7E);
      apply(7'h7F);
    end
    for (int k = 0; k < 21; k++)
    begin
      setf(k % 7, k < 20 ? 6'(6'h20 + k) : 6'h36);
      r = rnd();
      apply(r[6:0]);
    end
    ahb(1'b1, 32'h0000001C, 32'hFFFFFFFF, rd);
    ahb(1'b0, 32'h0000001C, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h00000040, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test directed maps done");
    for (int i = 0; i < 25; i++)
    begin
      for (int k = 0; k < 7; k++)
      begin
        r = rnd();
        setf(k, r[31] ? codes[r[3:0]] : r[9:4]);
      end
      r = rnd();
      ct = r[6:0];
      slow <= r[7];
      ahb(1'b1, 32'(`OFS_CONTACT), {25'h0, ct}, rd);
      ahb(1'b0, 32'(`OFS_CONTACT), 32'h0, rd);
      chk(rd, {25'h0, ct});
      ahb(1'b0, 32'(`OFS_FSEL0 + 4 * (r[10:8] % 7)), 32'h0, rd);
      chk(rd, {26'h0, fs[r[10:8] % 7]});
      for (int k = 0; k < 3; k++)
      begin
        r = rnd();
        apply(r[6:0]);
      end
    end
    $display("test random done");
    print_verdict();
  end
endmodule // tb_input_function_mapper
